/* File: inc/csw_pkg.sv */
// Shared constants, types and register layout of the system clock switch.
package csw_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] CSW_OFF_CONTROL = 8'h00;
    localparam logic [7:0] CSW_OFF_STATUS = 8'h04;
    localparam logic [7:0] CSW_OFF_CONFIG = 8'h08;

    localparam int CSW_CTL_PLL_BIT = 7;
    localparam int CSW_CTL_FREQ_LSB = 3;
    localparam int CSW_CTL_SCS_LSB = 0;
    localparam int CSW_STA_T1_BIT = 7;
    localparam int CSW_STA_PLL_BIT = 6;
    localparam int CSW_STA_EXT_BIT = 5;
    localparam int CSW_STA_FAST_BIT = 4;
    localparam int CSW_STA_MED_BIT = 2;
    localparam int CSW_STA_SLOW_BIT = 1;
    localparam int CSW_CFG_MODE_LSB = 0;
    localparam int CSW_CFG_PLL_BIT = 3;
    localparam int CSW_CFG_TWO_BIT = 4;
    localparam int CSW_CFG_FAIL_BIT = 5;

    localparam logic [3:0] CSW_FREQ_RESET = 4'h7;
    localparam logic [3:0] CSW_FREQ_PLL = 4'hE;
    localparam logic [1:0] CSW_SCS_RESET = 2'h0;
    localparam logic [1:0] CSW_SCS_TIMER1 = 2'h1;
    localparam logic [2:0] CSW_MODE_LOW_POWER = 3'h0;
    localparam logic [2:0] CSW_MODE_STANDARD = 3'h1;
    localparam logic [2:0] CSW_MODE_HIGH_SPEED = 3'h2;
    localparam logic [2:0] CSW_MODE_INTERNAL = 3'h4;
    localparam logic [2:0] CSW_MODE_RESET = 3'h4;
    localparam logic [10:0] CSW_OST_COUNT = 11'h400;

    // Index of each oscillator in the level and enable vectors.
    typedef enum logic [2:0] {
        SRC_SLOW, SRC_MED, SRC_FAST, SRC_PLL, SRC_EXT, SRC_T1
    } csw_src_type;

    typedef enum logic [2:0] {
        ST_RUN, ST_WAIT_READY, ST_WAIT_FALL, ST_HOLD_LOW, ST_UPDATE
    } csw_fsm_type;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } csw_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } csw_apb_rsp_type;

    // Level of each oscillator indexed by csw_src_type, and the raw ready flags.
    typedef struct packed {
        logic [5:0] level;
        logic [4:0] ready;
    } csw_osc_in_type;

endpackage : csw_pkg

/* File: logic/csw_clock_switch.sv */
// System clock source selection and glitch-free handover with two-speed start-up.
// What this block does
// - 32 MHz only in internal mode, source select 00, frequency 1110, PLL enabled.
// - With PLL forced by configuration, software cannot disable it; 8 MHz unavailable.
// - Internal oscillator never goes through the PLL when source select is 1x.
// - New internal frequency waits for its oscillator start-up before handover begins.
// - Handover waits for old clock falling edge, holds low, resumes on new rise.
// - Oscillator running bits update after new clock is active, before completion.
// - Frequency change within the same oscillator switches with no start-up delay.
// - Source select 00 configured mode, 01 Timer1 oscillator, 1x internal block.
// - Every reset clears source select.
// - Automatic switches leave source select alone; running-source bit shows truth.
// - External running bit set only when running from configured primary source.
// - Crystal modes count 1024 external oscillations before the crystal is used.
// - Two-speed start-up is off for all non-crystal modes.
// - Start-up count finished while awake sets running bit and moves to crystal.
// - Sleep aborts the start-up count and leaves the running bit clear.
// - Two-speed needs its enable bit or the fail monitor bit, source select 00 and a crystal mode.
// - Two-speed runs after power-up and after wake, executing from internal oscillator.
// - Clock fail monitor enabled forces two-speed start-up on.
// - Timer1 or crystal sources wait 1024 oscillations before use.
// - Internal oscillators leaving sleep or power-on are not held for warm-up; only a handover waits for ready, the current source is used at once.
// - Frequency select resets to 0111; 000x slow oscillator, 1111 16 MHz.
// - PLL configuration bit set keeps the PLL on regardless of software.
//
// The implementer's own choices: the APB slave port and the address map.
module csw_clock_switch (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire csw_pkg::csw_apb_req_type apb_req,
    output csw_pkg::csw_apb_rsp_type apb_rsp,
    input wire csw_pkg::csw_osc_in_type osc_in,
    input wire logic power_up_done,
    input wire logic sleep_enter,
    input wire logic wake_up,
    input wire logic clock_fail_detect,
    output logic sys_clk_out,
    output csw_pkg::csw_src_type active_src,
    output logic [3:0] active_freq,
    output logic switch_busy,
    output logic [5:0] osc_enable
);
    import csw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic soft_pll_enable;
        logic [3:0] internal_freq_select;
        logic [1:0] clock_source_select;
        logic [2:0] config_osc_mode;
        logic config_pll_force;
        logic two_speed_enable;
        logic clock_fail_monitor;
        logic [4:0] rdy_s1;
        logic [4:0] rdy_s2;
        logic [5:0] level_prev;
        csw_src_type cur_src;
        csw_src_type tgt_src;
        csw_fsm_type fsm;
        logic [10:0] ost_cnt;
        logic ost_done;
        logic sleeping;
        logic fail_active;
        logic external_clock_running;
        logic [4:0] status_rdy;
        logic sys_clk;
        logic [5:0] osc_en;
        logic [3:0] freq_out;
        logic busy;
        csw_apb_rsp_type rsp;
    } csw_state_type;

    csw_state_type st;
    csw_state_type next_st;

    // Oscillator that a frequency select code is derived from.
    function automatic csw_src_type freq_src(input logic [3:0] f);
        if (f[3:1] == 3'h0) begin
            return SRC_SLOW;
        end else if (f == 4'h2 || (f[3:2] == 2'h1)) begin
            return SRC_MED;
        end else begin
            return SRC_FAST;
        end
    endfunction : freq_src

    function automatic logic is_crystal(input logic [2:0] m);
        return m == CSW_MODE_LOW_POWER || m == CSW_MODE_STANDARD || m == CSW_MODE_HIGH_SPEED;
    endfunction : is_crystal

    ////////////////////////////////////////////////////////////////////////////////
    logic pll_on;
    logic two_speed_on;
    logic apb_access;
    logic apb_write;
    logic [7:0] status_word;
    logic [5:0] fall_edge;
    logic [5:0] rise_edge;
    csw_src_type want_src;
    csw_src_type ost_src;
    logic want_ready;

    always_comb begin
        pll_on = st.config_pll_force | st.soft_pll_enable;
        two_speed_on = (st.two_speed_enable | st.clock_fail_monitor)
            & (st.clock_source_select == CSW_SCS_RESET) & is_crystal(st.config_osc_mode);
        apb_access = apb_req.psel & apb_req.penable & ~st.rsp.pready;
        // Writes land at the edge where the master sees pready high, ending the transfer.
        apb_write = apb_req.psel & apb_req.penable & apb_req.pwrite & st.rsp.pready;
        fall_edge = st.level_prev & ~osc_in.level;
        rise_edge = ~st.level_prev & osc_in.level;
        ost_src = (st.clock_source_select == CSW_SCS_TIMER1) ? SRC_T1 : SRC_EXT;
        status_word = 8'h00;
        status_word[CSW_STA_T1_BIT] = st.status_rdy[4];
        status_word[CSW_STA_PLL_BIT] = st.status_rdy[3];
        status_word[CSW_STA_EXT_BIT] = st.external_clock_running;
        status_word[CSW_STA_FAST_BIT] = st.status_rdy[2];
        status_word[CSW_STA_MED_BIT] = st.status_rdy[1];
        status_word[CSW_STA_SLOW_BIT] = st.status_rdy[0];
        // Selection of the wanted source.
        if (st.clock_source_select[1]) begin
            want_src = freq_src(st.internal_freq_select);
        end else if (st.clock_source_select == CSW_SCS_TIMER1) begin
            want_src = SRC_T1;
        end else if (st.fail_active) begin
            want_src = freq_src(st.internal_freq_select);
        end else if (st.config_osc_mode == CSW_MODE_INTERNAL) begin
            if (st.internal_freq_select == CSW_FREQ_PLL && pll_on) begin
                want_src = SRC_PLL;
            end else begin
                want_src = freq_src(st.internal_freq_select);
            end
        end else if (two_speed_on && !st.ost_done) begin
            want_src = freq_src(st.internal_freq_select);
        end else begin
            want_src = SRC_EXT;
        end
        case (st.tgt_src)
            SRC_SLOW: want_ready = st.rdy_s2[0];
            SRC_MED: want_ready = st.rdy_s2[1];
            SRC_FAST: want_ready = st.rdy_s2[2];
            SRC_PLL: want_ready = st.rdy_s2[3];
            SRC_EXT: want_ready = st.ost_done | ~is_crystal(st.config_osc_mode);
            SRC_T1: want_ready = st.rdy_s2[4] & st.ost_done;
            default: want_ready = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.rdy_s1 = osc_in.ready;
        next_st.rdy_s2 = st.rdy_s1;
        next_st.level_prev = osc_in.level;
        next_st.rsp.pready = apb_access;
        next_st.rsp.pslverr = 1'b0;
        next_st.rsp.prdata = 32'h0000_0000;

        // Register access.
        if (apb_access) begin
            case (apb_req.paddr[7:0])
                CSW_OFF_CONTROL: begin
                    next_st.rsp.prdata[7:0] = {st.soft_pll_enable, st.internal_freq_select, 1'b0,
                        st.clock_source_select};
                end
                CSW_OFF_STATUS: begin
                    next_st.rsp.prdata[7:0] = status_word;
                end
                CSW_OFF_CONFIG: begin
                    next_st.rsp.prdata[5:0] = {st.clock_fail_monitor, st.two_speed_enable,
                        st.config_pll_force, st.config_osc_mode};
                end
                default: begin
                    next_st.rsp.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_write && apb_req.paddr[7:0] == CSW_OFF_CONTROL) begin
            next_st.soft_pll_enable = apb_req.pwdata[CSW_CTL_PLL_BIT];
            next_st.internal_freq_select = apb_req.pwdata[CSW_CTL_FREQ_LSB +: 4];
            next_st.clock_source_select = apb_req.pwdata[CSW_CTL_SCS_LSB +: 2];
        end
        if (apb_write && apb_req.paddr[7:0] == CSW_OFF_CONFIG) begin
            next_st.config_osc_mode = apb_req.pwdata[CSW_CFG_MODE_LSB +: 3];
            next_st.config_pll_force = apb_req.pwdata[CSW_CFG_PLL_BIT];
            next_st.two_speed_enable = apb_req.pwdata[CSW_CFG_TWO_BIT];
            next_st.clock_fail_monitor = apb_req.pwdata[CSW_CFG_FAIL_BIT];
        end

        // A new source select restarts the start-up timer and ends a fail condition.
        if (apb_write && apb_req.paddr[7:0] == CSW_OFF_CONTROL
            && apb_req.pwdata[CSW_CTL_SCS_LSB +: 2] != st.clock_source_select) begin
            next_st.ost_cnt = 11'h000;
            next_st.ost_done = 1'b0;
            next_st.fail_active = 1'b0;
        end else if (st.clock_fail_monitor && clock_fail_detect && st.ost_done) begin
            next_st.fail_active = 1'b1;
        end

        // Start-up timer counts falling edges of the oscillator being started.
        if (!st.sleeping && power_up_done && !st.ost_done && fall_edge[ost_src]) begin
            if (st.ost_cnt == CSW_OST_COUNT - 11'h001) begin
                next_st.ost_done = 1'b1;
            end
            next_st.ost_cnt = st.ost_cnt + 11'h001;
        end

        // Handover sequencer.
        case (st.fsm)
            ST_RUN: begin
                next_st.sys_clk = osc_in.level[st.cur_src];
                next_st.status_rdy = st.rdy_s2;
                if (!st.sleeping && want_src != st.cur_src) begin
                    next_st.tgt_src = want_src;
                    next_st.fsm = ST_WAIT_READY;
                end
                if (freq_src(st.internal_freq_select) == st.cur_src) begin
                    next_st.freq_out = st.internal_freq_select;
                end
            end
            ST_WAIT_READY: begin
                next_st.sys_clk = osc_in.level[st.cur_src];
                if (want_ready) begin
                    next_st.fsm = ST_WAIT_FALL;
                end
            end
            ST_WAIT_FALL: begin
                next_st.sys_clk = osc_in.level[st.cur_src];
                if (fall_edge[st.cur_src]) begin
                    next_st.sys_clk = 1'b0;
                    next_st.fsm = ST_HOLD_LOW;
                end
            end
            ST_HOLD_LOW: begin
                next_st.sys_clk = 1'b0;
                if (rise_edge[st.tgt_src]) begin
                    next_st.sys_clk = 1'b1;
                    next_st.cur_src = st.tgt_src;
                    next_st.freq_out = st.internal_freq_select;
                    if (st.tgt_src != SRC_EXT) begin
                        next_st.external_clock_running = 1'b0;
                    end
                    next_st.fsm = ST_UPDATE;
                end
            end
            ST_UPDATE: begin
                next_st.sys_clk = osc_in.level[st.cur_src];
                next_st.status_rdy = st.rdy_s2;
                next_st.external_clock_running = (st.cur_src == SRC_EXT);
                next_st.fsm = ST_RUN;
            end
            default: begin
                next_st.fsm = ST_RUN;
            end
        endcase

        // Sleep aborts any start-up count; wake restarts it for two-speed start-up.
        if (sleep_enter) begin
            next_st.sleeping = 1'b1;
            next_st.ost_cnt = 11'h000;
            next_st.ost_done = 1'b0;
            next_st.external_clock_running = 1'b0;
            next_st.fail_active = 1'b0;
        end else if (wake_up) begin
            next_st.sleeping = 1'b0;
        end

        next_st.osc_en = 6'h00;
        next_st.osc_en[st.cur_src] = 1'b1;
        next_st.osc_en[st.tgt_src] = ~st.sleeping;
        next_st.osc_en[ost_src] = ~st.sleeping & ~st.ost_done;
        if (pll_on) begin
            next_st.osc_en[SRC_PLL] = ~st.sleeping;
        end
        next_st.busy = (next_st.fsm != ST_RUN);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.internal_freq_select <= CSW_FREQ_RESET;
            st.clock_source_select <= CSW_SCS_RESET;
            st.config_osc_mode <= CSW_MODE_RESET;
            st.cur_src <= SRC_MED;
            st.tgt_src <= SRC_MED;
            st.fsm <= ST_RUN;
            st.freq_out <= CSW_FREQ_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign apb_rsp = st.rsp;
    assign sys_clk_out = st.sys_clk;
    assign active_src = st.cur_src;
    assign active_freq = st.freq_out;
    assign switch_busy = st.busy;
    assign osc_enable = st.osc_en;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    pll_select_a: assert property ((st.fsm == ST_HOLD_LOW && st.tgt_src == SRC_PLL)
        |-> st.clock_source_select == 2'h0 && st.internal_freq_select == CSW_FREQ_PLL
        && st.config_osc_mode == CSW_MODE_INTERNAL && pll_on)
        else $error("PLL selected without the required settings.");
    pll_forced_a: assert property (st.config_pll_force |-> pll_on)
        else $error("Forced PLL is not on.");
    hold_low_a: assert property (st.fsm == ST_HOLD_LOW |-> !sys_clk_out)
        else $error("System clock not held low during handover.");
    no_pll_int_a: assert property (st.clock_source_select[1] && st.fsm == ST_WAIT_READY
        |-> st.tgt_src != SRC_PLL)
        else $error("PLL used with internal source select.");
    ost_count_a: assert property ($rose(st.ost_done) |-> $past(st.ost_cnt) == CSW_OST_COUNT - 11'h001)
        else $error("Start-up timer finished at the wrong count.");
    sleep_abort_a: assert property (sleep_enter |=> !st.ost_done && !st.external_clock_running)
        else $error("Sleep did not abort the start-up timer.");
    auto_keep_a: assert property (!apb_write |=> $stable(st.clock_source_select))
        else $error("Source select changed without a write.");
    ext_flag_a: assert property (st.external_clock_running |-> st.cur_src == SRC_EXT)
        else $error("Running flag set while not on the primary source.");
    status_upd_a: assert property (st.fsm == ST_UPDATE |=> st.status_rdy == $past(st.rdy_s2))
        else $error("Status not updated after handover.");

    pll_switch_c: cover property (st.fsm == ST_UPDATE && st.cur_src == SRC_PLL);
    two_speed_c: cover property (st.fsm == ST_UPDATE && st.external_clock_running);
    sleep_abort_c: cover property (sleep_enter && st.ost_cnt != 11'h000);

endmodule : csw_clock_switch

/* File: tb/tb_top.sv */
// Self-checking testbench of the system clock switch.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csw_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic err;
    } tb_note_type;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    csw_apb_req_type apb_req = '0;
    csw_apb_rsp_type apb_rsp;
    csw_osc_in_type osc_in = '0;
    logic power_up_done = 1'b0;
    logic sleep_enter = 1'b0;
    logic wake_up = 1'b0;
    logic clock_fail_detect = 1'b0;
    logic sys_clk_out;
    csw_src_type active_src;
    logic [3:0] active_freq;
    logic switch_busy;
    logic [5:0] osc_enable;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    tb_note_type exp_q[$];
    tb_note_type note;
    logic [31:0] rnd;
    logic hi;
    logic lo;
    ////////////////////////////////////////////////////////////////////////////////
    csw_clock_switch u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .osc_in(osc_in), .power_up_done(power_up_done), .sleep_enter(sleep_enter),
        .wake_up(wake_up), .clock_fail_detect(clock_fail_detect), .sys_clk_out(sys_clk_out),
        .active_src(active_src), .active_freq(active_freq), .switch_busy(switch_busy),
        .osc_enable(osc_enable)
    );
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task check(string name, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    // Oscillators run at fixed ratios of the bench clock; the hang limit lives here too.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        osc_in.level <= {cyc[1], cyc[1], cyc[0], cyc[0], cyc[0], cyc[2]};
        if (cyc > 40000) begin
            n_errors++;
            end_of_test();
        end
    end
    // Every answer of the slave retires the oldest expectation.
    always @(negedge ref_clk) begin
        if (apb_rsp.pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected pready", 32'h1, 32'h0);
            end else begin
                note = exp_q.pop_front();
                check("prdata", apb_rsp.prdata & note.mask, note.data);
                check("pslverr", {31'h0, apb_rsp.pslverr}, {31'h0, note.err});
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task xfer(logic [7:0] a, logic w, logic [31:0] d, logic [31:0] e, logic [31:0] m, logic err);
        int n;
        n = 0;
        exp_q.push_back('{data: e & m, mask: m, err: err});
        @(posedge ref_clk);
        apb_req.paddr <= {24'h00, a};
        apb_req.pwrite <= w;
        apb_req.pwdata <= d;
        apb_req.psel <= 1'b1;
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(negedge ref_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) check("pready", 32'h0, 32'h1);
        @(posedge ref_clk);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : xfer
    task wait_src(csw_src_type s, int lim);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (!(active_src === s && switch_busy === 1'b0) && n < lim);
    endtask : wait_src
    task pulse(int which);
        @(posedge ref_clk);
        if (which == 0) sleep_enter <= 1'b1;
        else wake_up <= 1'b1;
        @(posedge ref_clk);
        sleep_enter <= 1'b0;
        wake_up <= 1'b0;
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        osc_in.ready = 5'h1F;
        rnd = $urandom(38);
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        power_up_done <= 1'b1;
        xfer(CSW_OFF_CONTROL, 1'b0, 32'h0, 32'h38, '1, 1'b0);
        xfer(CSW_OFF_CONFIG, 1'b0, 32'h0, 32'h04, '1, 1'b0);
        xfer(8'h0C, 1'b1, 32'h5A, 32'h0, '1, 1'b1);
        xfer(8'h0C, 1'b0, 32'h0, 32'h0, '1, 1'b1);
        check("src", 32'(active_src), 32'(SRC_MED));
        // Medium to fast with random upper data bits that must read back as zero.
        rnd = $urandom();
        xfer(CSW_OFF_CONTROL, 1'b1, {rnd[31:8], 8'h7A}, 32'h0, 32'h0, 1'b0);
        xfer(CSW_OFF_CONTROL, 1'b0, 32'h0, 32'h7A, '1, 1'b0);
        wait_src(SRC_FAST, 200);
        check("src", 32'(active_src), 32'(SRC_FAST));
        check("freq", {28'h0, active_freq}, 32'hF);
        check("fast enable", {31'h0, osc_enable[SRC_FAST]}, 32'h1);
        xfer(CSW_OFF_STATUS, 1'b0, 32'h0, 32'h10, 32'h30, 1'b0);
        // Another fast-derived code: no handover is expected.
        rnd = 32'hB + ($urandom() % 3);
        xfer(CSW_OFF_CONTROL, 1'b1, {25'h0, rnd[3:0], 3'h2}, 32'h0, 32'h0, 1'b0);
        repeat (3) @(negedge ref_clk);
        check("busy", {31'h0, switch_busy}, 32'h0);
        check("freq", {28'h0, active_freq}, rnd);
        // Slow oscillator held not ready: handover must wait for it.
        @(posedge ref_clk);
        osc_in.ready[0] <= 1'b0;
        xfer(CSW_OFF_CONTROL, 1'b1, 32'h02, 32'h0, 32'h0, 1'b0);
        repeat (20) @(negedge ref_clk);
        check("busy", {31'h0, switch_busy}, 32'h1);
        check("src", 32'(active_src), 32'(SRC_FAST));
        @(posedge ref_clk);
        osc_in.ready[0] <= 1'b1;
        wait_src(SRC_SLOW, 200);
        check("src", 32'(active_src), 32'(SRC_SLOW));
        // Multiplier paths: forced, neither, software bit with select 1x, software bit with select 00.
        xfer(CSW_OFF_CONFIG, 1'b1, 32'h0C, 32'h0, 32'h0, 1'b0);
        xfer(CSW_OFF_CONTROL, 1'b1, 32'h70, 32'h0, 32'h0, 1'b0);
        wait_src(SRC_PLL, 300);
        check("src", 32'(active_src), 32'(SRC_PLL));
        xfer(CSW_OFF_CONFIG, 1'b1, 32'h04, 32'h0, 32'h0, 1'b0);
        wait_src(SRC_FAST, 300);
        check("src", 32'(active_src), 32'(SRC_FAST));
        xfer(CSW_OFF_CONTROL, 1'b1, 32'hF2, 32'h0, 32'h0, 1'b0);
        repeat (30) @(negedge ref_clk);
        check("src", 32'(active_src), 32'(SRC_FAST));
        xfer(CSW_OFF_CONTROL, 1'b1, 32'hF0, 32'h0, 32'h0, 1'b0);
        wait_src(SRC_PLL, 300);
        check("src", 32'(active_src), 32'(SRC_PLL));
        // Timer1 oscillator: usable only after its start-up count.
        xfer(CSW_OFF_CONTROL, 1'b1, 32'h39, 32'h0, 32'h0, 1'b0);
        wait_src(SRC_T1, 1000);
        check("t1 early", {31'h0, active_src === SRC_T1}, 32'h0);
        wait_src(SRC_T1, 5000);
        check("src", 32'(active_src), 32'(SRC_T1));
        xfer(CSW_OFF_STATUS, 1'b0, 32'h0, 32'h0, 32'h20, 1'b0);
        // Crystal with two-speed start-up, aborted by sleep and resumed on wake.
        xfer(CSW_OFF_CONFIG, 1'b1, 32'h11, 32'h0, 32'h0, 1'b0);
        xfer(CSW_OFF_CONTROL, 1'b1, 32'h38, 32'h0, 32'h0, 1'b0);
        repeat (200) @(negedge ref_clk);
        pulse(0);
        xfer(CSW_OFF_STATUS, 1'b0, 32'h0, 32'h0, 32'h20, 1'b0);
        pulse(1);
        wait_src(SRC_EXT, 1000);
        check("src", 32'(active_src), 32'(SRC_MED));
        wait_src(SRC_EXT, 5000);
        check("src", 32'(active_src), 32'(SRC_EXT));
        xfer(CSW_OFF_STATUS, 1'b0, 32'h0, 32'h20, 32'h20, 1'b0);
        xfer(CSW_OFF_CONTROL, 1'b0, 32'h0, 32'h38, '1, 1'b0);
        // Second reset in mid-run, with a non-zero source select that it must clear.
        xfer(CSW_OFF_CONTROL, 1'b1, 32'h7A, 32'h0, 32'h0, 1'b0);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        xfer(CSW_OFF_CONTROL, 1'b0, 32'h0, 32'h38, '1, 1'b0);
        check("src", 32'(active_src), 32'(SRC_MED));
        check("med enable", {31'h0, osc_enable[SRC_MED]}, 32'h1);
        hi = 1'b0;
        lo = 1'b0;
        repeat (8) begin
            @(negedge ref_clk);
            hi = hi | (sys_clk_out === 1'b1);
            lo = lo | (sys_clk_out === 1'b0);
        end
        check("sys_clk toggles", {30'h0, hi, lo}, 32'h3);
        repeat (5) @(posedge ref_clk);
        end_of_test();
    end
endmodule : tb_top
